// File: dv/buffer_and_dma_write_cmds_tb.sv
// self-checking bench for the buffer and dma write command block
`timescale 1ns/1ns
module buffer_and_dma_write_cmds_tb
  import wrcmd_pkg::*;
;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic cyc, stb, we, ack, dma_req;
  logic [3:0] adr, sel;
  logic [31:0] dat, dat_o;
  logic [7:0] v;
  logic [7:0] dsh_val = 8'h50;
  logic [7:0] env_tab [4] = '{8'h05, 8'h09, 8'h21, 8'h01};
  logic [7:0] hi_tab [4] = '{8'h00, 8'h00, 8'h00, 8'hff};
  logic [7:0] err_tab [4] = '{8'h02, 8'h40, 8'h10, 8'h10};
  int num_errors = 0;
  int tests_run = 0;

  // 250 mhz clock
  always #2 CLK = ~CLK;

  wrcmd_host h (.CLK(CLK), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat(dat), .dat_i(dat_o), .ack(ack), .dma_req(dma_req));

  wrcmd_core DUT (.CLK(CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .DMA_REQ(dma_req));

  // compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task rc(input logic [3:0] ix, input logic [7:0] exp);
    h.xfer(1'b0, ix, 8'h00, v);
    chk(v, exp);
  endtask

  task w(input logic [3:0] ix, input logic [7:0] val);
    h.xfer(1'b1, ix, val, v);
  endtask

  // taskfile setup, start address 0xfe with hi in the address high register, drive one, mode from dsh_val
  task go(input logic [7:0] env, cnt, hi, op);
    w(IX_ENV_CTRL, env);
    w(IX_COUNT, cnt);
    w(IX_ADDR_LOW, 8'hfe);
    w(IX_ADDR_MID, 8'h00);
    w(IX_ADDR_HIGH, hi);
    w(IX_DSH, dsh_val);
    h.cmd(op);
  endtask

  task end_sim();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog at 50k cycles, run needs well under that
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rc(IX_CMD_STAT, 8'h40);
    rc(IX_ENV_CTRL, 8'h01);
    rc(4'hc, 8'h00);
    w(IX_DSH, 8'hff);
    rc(IX_DSH, 8'h5f);
    w(IX_FEATURE, 8'hff);
    rc(IX_FEATURE, 8'h00);
    // a write without lane 0 must leave the register alone
    h.lanes = 4'he;
    w(IX_COUNT, 8'h55);
    h.lanes = 4'h1;
    rc(IX_COUNT, 8'h00);
    $display("test reset done");
    // buffer write, exactly 512 bytes end the data phase
    w(IX_DSH, 8'h10);
    w(IX_COUNT, 8'h00);
    h.cmd(OP_BUF_WRITE);
    rc(IX_CMD_STAT, 8'h48);
    repeat (511) w(IX_PIO_DATA, 8'ha5);
    rc(IX_CMD_STAT, 8'h48);
    w(IX_PIO_DATA, 8'h3c);
    rc(IX_CMD_STAT, 8'h40);
    rc(IX_ERROR, 8'h00);
    rc(IX_DSH, 8'h10);
    w(IX_ENV_CTRL, 8'h00);
    h.cmd(OP_BUF_WRITE);
    rc(IX_ERROR, 8'h04);
    rc(IX_CMD_STAT, 8'h41);
    $display("test buffer write done");
    // packet-set device refuses both commands
    foreach (env_tab[i])
    begin
      if (i < 2)
      begin
        w(IX_ENV_CTRL, 8'h03);
        h.cmd(i == 0 ? OP_BUF_WRITE : OP_DMA_WRITE);
        rc(IX_ERROR, 8'h04);
      end
      // bad geometry only counts in cylinder/head/sector mode
      dsh_val = (i == 2) ? 8'h10 : 8'h50;
      go(env_tab[i], 8'h01, hi_tab[i], OP_DMA_WRITE);
      rc(IX_ERROR, err_tab[i]);
      rc(IX_CMD_STAT, 8'h41);
    end
    $display("test start errors done");
    // media change reported once, then a clean transfer
    w(IX_ENV_EVT, 8'h01);
    go(8'h01, 8'h01, 8'h00, OP_DMA_WRITE);
    rc(IX_ERROR, 8'h20);
    go(8'h01, 8'h01, 8'h00, OP_DMA_WRITE);
    h.dma(512);
    rc(IX_ERROR, 8'h00);
    w(IX_ENV_EVT, 8'h02);
    go(8'h01, 8'h01, 8'h00, OP_DMA_WRITE);
    rc(IX_ERROR, 8'h08);
    $display("test media events done");
    // two sectors by dma
    go(8'h01, 8'h02, 8'h00, OP_DMA_WRITE);
    rc(IX_CMD_STAT, 8'hc0);
    chk({7'h0, dma_req}, 8'h01);
    h.dma(1024);
    chk({7'h0, dma_req}, 8'h00);
    rc(IX_CMD_STAT, 8'h40);
    rc(IX_ERROR, 8'h00);
    // zero count keeps going past two sectors, then fails at 0x100
    go(8'h01, 8'h00, 8'h00, OP_DMA_WRITE);
    h.dma(1024);
    chk({7'h0, dma_req}, 8'h01);
    w(IX_ENV_EVT, 8'h10);
    rc(IX_ERROR, 8'h04);
    rc(IX_ADDR_LOW, 8'h00);
    rc(IX_ADDR_MID, 8'h01);
    rc(IX_DSH, 8'h10);
    $display("test dma transfers done");
    // faults in mid transfer
    go(8'h01, 8'h01, 8'h00, OP_DMA_WRITE);
    h.dma(8);
    w(IX_ENV_EVT, 8'h04);
    rc(IX_CMD_STAT, 8'h61);
    go(8'h11, 8'h01, 8'h00, OP_DMA_WRITE);
    h.dma(8);
    w(IX_ENV_EVT, 8'h08);
    rc(IX_ERROR, 8'h84);
    go(8'h01, 8'h01, 8'h00, OP_DMA_WRITE);
    w(IX_ENV_EVT, 8'h08);
    h.dma(512);
    rc(IX_ERROR, 8'h00);
    rc(IX_CMD_STAT, 8'h40);
    $display("test dma faults done");
    // reset in mid transfer drops the request and restores defaults
    go(8'h01, 8'h01, 8'h00, OP_DMA_WRITE);
    h.dma(8);
    @(posedge CLK);
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    rc(IX_CMD_STAT, 8'h40);
    chk({7'h0, dma_req}, 8'h00);
    rc(IX_ENV_CTRL, 8'h01);
    $display("test mid reset done");
    end_sim();
  end
endmodule

// File: dv/wrcmd_host.sv
// host adapter model: wishbone master for taskfile and dma channel
`timescale 1ns/1ns
module wrcmd_host
  import wrcmd_pkg::*;
(
  // clock
  input wire logic CLK,
  // wishbone master side
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [3:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  // slave answer
  input wire logic [31:0] dat_i,
  input wire logic ack,
  // dma channel request from the device
  input wire logic dma_req
);
  // byte lanes for the next cycle; lane 0 alone carries register writes
  logic [3:0] lanes = 4'h1;
  // idle bus at time zero
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    dat = 32'h0;
  end

  // one classic cycle, held until ack is sampled high
  task xfer(input logic w, input logic [3:0] ix, input logic [7:0] v,
            output logic [7:0] r);
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ix;
    sel <= lanes;
    dat <= {24'h0, v};
    do @(posedge CLK); while (ack !== 1'b1);
    r = dat_i[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // released lines must not keep the old value
    adr <= ~ix;
    dat <= ~{24'h0, v};
  endtask

  // command issue only if one status read reports ready, otherwise the command is dropped
  task cmd(input logic [7:0] op);
    logic [7:0] s;
    xfer(1'b0, IX_CMD_STAT, 8'h00, s);
    if (s[ST_DEVICE_READY_FLAG] === 1'b1)
      xfer(1'b1, IX_CMD_STAT, op, s);
  endtask

  // dma channel pushes bytes only while the device requests
  task dma(input int n);
    logic [7:0] s;
    for (int i = 0; i < n; i++)
    begin
      // settle past the edge so the request is seen as updated
      #1;
      if (dma_req === 1'b1)
        xfer(1'b1, IX_DMA_DATA, i[7:0], s);
    end
  endtask
endmodule

// File: rtl/wrcmd_core.sv
// buffer-write and dma-write command engine behind a wishbone slave
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/1ns
module wrcmd_core
  import wrcmd_pkg::*;
#(
  parameter logic [27:0] MAX_LBA = 28'h00fffff
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [5:2] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // dma channel request
  output logic DMA_REQ
);

  state_t st_q, st_d;
  logic ack_q, dmarq_q;
  logic [31:0] dat_q, dat_d;
  logic [7:0] cnt_q, cnt_d, alo_q, alo_d, amid_q, amid_d;
  logic [7:0] ahi_q, ahi_d, error_q, error_d, e;
  logic [3:0] head_q, head_d;
  logic lba_q, lba_d, dev_q, dev_d, fault_q, fault_d;
  logic mc_q, mc_d, mcr_q, mcr_d;
  logic [5:0] env_q, env_d;
  logic [8:0] idx_q, idx_d, bytes_q, bytes_d, left_q, left_d;
  logic [27:0] cur_q, cur_d, start_addr;
  logic [8:0] xfer_len;
  logic [28:0] last_addr;
  logic [7:0] status;
  logic [7:0] buf_mem [0:511];
  logic req, wr, cmd_wr, mem_we, fin_ok, fin_err, fin_addr;
  logic [4:0] ev;

  // true for a write to a given register in the accept cycle
  function automatic logic hit(input logic w, input logic [3:0] a,
                               input logic [3:0] ix);
    hit = w && (a == ix);
  endfunction

  // bus accept: one request per ack, writes take lane 0 only
  assign req = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr = req && WB_WE_I && WB_SEL_I[0];
  assign cmd_wr = hit(wr, WB_ADR_I, IX_CMD_STAT) && (st_q == ST_IDLE);
  assign ev = hit(wr, WB_ADR_I, IX_ENV_EVT) ? WB_DAT_I[4:0] : 5'h00;

  // address and length as the command sees them
  assign start_addr = {head_q, ahi_q, amid_q, alo_q};
  assign xfer_len = (cnt_q == CNT_ZERO) ? SECT_FULL : {1'b0, cnt_q};
  assign last_addr = {1'b0, start_addr} + {20'h00000, xfer_len} - 29'h1;

  // status byte; busy shows the dma burst, request the pio phase
  always_comb
  begin
    status = 8'h00;
    status[ST_BUSY] = (st_q == ST_DMA);
    status[ST_DEVICE_READY_FLAG] = 1'b1;
    status[ST_DF] = fault_q;
    status[ST_DRQ] = (st_q == ST_PIO);
    status[ST_ERR] = (error_q != 8'h00);
  end

  // command engine next state
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    alo_d = alo_q;
    amid_d = amid_q;
    ahi_d = ahi_q;
    head_d = head_q;
    lba_d = lba_q;
    dev_d = dev_q;
    error_d = error_q;
    fault_d = fault_q;
    mc_d = mc_q;
    mcr_d = mcr_q;
    env_d = env_q;
    idx_d = idx_q;
    bytes_d = bytes_q;
    left_d = left_q;
    cur_d = cur_q;
    mem_we = 1'b0;
    fin_ok = 1'b0;
    fin_err = 1'b0;
    fin_addr = 1'b0;
    e = 8'h00;
    // taskfile writes are only honoured while idle
    if (wr && st_q == ST_IDLE)
    begin
      case (WB_ADR_I)
        IX_COUNT: cnt_d = WB_DAT_I[7:0];
        IX_ADDR_LOW: alo_d = WB_DAT_I[7:0];
        IX_ADDR_MID: amid_d = WB_DAT_I[7:0];
        IX_ADDR_HIGH: ahi_d = WB_DAT_I[7:0];
        IX_DSH:
        begin
          lba_d = WB_DAT_I[DSH_LBA];
          dev_d = WB_DAT_I[DSH_DEV];
          head_d = WB_DAT_I[3:0];
        end
        default: ;
      endcase
    end
    if (hit(wr, WB_ADR_I, IX_ENV_CTRL))
      env_d = WB_DAT_I[5:0];
    // command start
    if (cmd_wr)
    begin
      error_d = 8'h00;
      fault_d = 1'b0;
      if (WB_DAT_I[7:0] == OP_BUF_WRITE)
      begin
        if (env_q[EC_PACKET] || !env_q[EC_BUF_SUP])
        begin
          error_d[ER_ABORTED_FLAG] = 1'b1;
          fin_err = 1'b1;
        end
        else
        begin
          st_d = ST_PIO;
          idx_d = 9'h000;
        end
      end
      else if (WB_DAT_I[7:0] == OP_DMA_WRITE && !env_q[EC_PACKET])
      begin
        e[ER_NM] = env_q[EC_NO_MEDIA];
        e[ER_WP] = env_q[EC_WPROT];
        e[ER_MC] = mc_q;
        e[ER_MCR] = mcr_q;
        // geometry only matters when the address is cylinder/head/sector
        e[ER_ADDR_NOT_FOUND_FLAG] = (!lba_q && env_q[EC_GEOM_BAD])
                     || (last_addr > {1'b0, MAX_LBA});
        mc_d = 1'b0;
        mcr_d = 1'b0;
        cur_d = start_addr;
        left_d = xfer_len;
        bytes_d = 9'h000;
        if (e != 8'h00)
        begin
          error_d = e;
          fin_err = 1'b1;
          fin_addr = 1'b1;
        end
        else
          st_d = ST_DMA;
      end
      else
      begin
        // anything else is outside this engine and is refused
        error_d[ER_ABORTED_FLAG] = 1'b1;
        fin_err = 1'b1;
      end
    end
    // data phases
    case (st_q)
      ST_IDLE: ;
      ST_PIO:
      begin
        if (ev[EV_FAULT])
        begin
          fault_d = 1'b1;
          error_d[ER_ABORTED_FLAG] = 1'b1;
          fin_err = 1'b1;
        end
        else if (hit(wr, WB_ADR_I, IX_PIO_DATA))
        begin
          mem_we = 1'b1;
          idx_d = idx_q + 9'h001;
          if (idx_q == SECT_LAST)
            fin_ok = 1'b1;
        end
      end
      ST_DMA:
      begin
        if (ev[EV_FAULT])
        begin
          fault_d = 1'b1;
          error_d[ER_ABORTED_FLAG] = 1'b1;
          fin_err = 1'b1;
          fin_addr = 1'b1;
        end
        else if (ev[EV_UNRECOV])
        begin
          error_d[ER_ABORTED_FLAG] = 1'b1;
          fin_err = 1'b1;
          fin_addr = 1'b1;
        end
        else if (ev[EV_CRC] && env_q[EC_ULTRA])
        begin
          // a crc slip on multiword dma is not reported here
          error_d[ER_INTERFACE_CRC_FLAG] = 1'b1;
          error_d[ER_ABORTED_FLAG] = 1'b1;
          fin_err = 1'b1;
          fin_addr = 1'b1;
        end
        else if (hit(wr, WB_ADR_I, IX_DMA_DATA))
        begin
          bytes_d = bytes_q + 9'h001;
          if (bytes_q == SECT_LAST)
          begin
            left_d = left_q - 9'h001;
            cur_d = cur_q + 28'h0000001;
            if (left_q == 9'h001)
              fin_ok = 1'b1;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // completion: inapplicable outputs read zero, select is kept
    if (fin_ok || fin_err)
    begin
      st_d = ST_IDLE;
      cnt_d = 8'h00;
      lba_d = 1'b0;
      {head_d, ahi_d, amid_d, alo_d} = fin_addr ? cur_d : 28'h0000000;
      if (fin_ok)
      begin
        error_d = 8'h00;
        fault_d = 1'b0;
      end
    end
    // detection events set last so they beat a same-cycle clear
    if (ev[EV_MEDIA_CHG])
      mc_d = 1'b1;
    if (ev[EV_CHG_REQ])
      mcr_d = 1'b1;
  end

  // read data mux, write-only and data ports read zero
  always_comb
  begin
    dat_d = 32'h00000000;
    if (req && !WB_WE_I)
    begin
      case (WB_ADR_I)
        IX_COUNT: dat_d[7:0] = cnt_q;
        IX_ADDR_LOW: dat_d[7:0] = alo_q;
        IX_ADDR_MID: dat_d[7:0] = amid_q;
        IX_ADDR_HIGH: dat_d[7:0] = ahi_q;
        IX_DSH: dat_d[7:0] = {1'b0, lba_q, 1'b0, dev_q, head_q};
        IX_CMD_STAT: dat_d[7:0] = status;
        IX_ERROR: dat_d[7:0] = error_q;
        IX_ENV_CTRL: dat_d[5:0] = env_q;
        default: dat_d = 32'h00000000;
      endcase
    end
  end

  // registers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_q <= ST_IDLE;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      dmarq_q <= 1'b0;
      cnt_q <= 8'h00;
      alo_q <= 8'h00;
      amid_q <= 8'h00;
      ahi_q <= 8'h00;
      head_q <= 4'h0;
      lba_q <= 1'b0;
      dev_q <= 1'b0;
      error_q <= 8'h00;
      fault_q <= 1'b0;
      mc_q <= 1'b0;
      mcr_q <= 1'b0;
      env_q <= ENV_RESET;
      idx_q <= 9'h000;
      bytes_q <= 9'h000;
      left_q <= 9'h000;
      cur_q <= 28'h0000000;
    end
    else
    begin
      st_q <= st_d;
      ack_q <= req;
      dat_q <= dat_d;
      dmarq_q <= (st_d == ST_DMA);
      cnt_q <= cnt_d;
      alo_q <= alo_d;
      amid_q <= amid_d;
      ahi_q <= ahi_d;
      head_q <= head_d;
      lba_q <= lba_d;
      dev_q <= dev_d;
      error_q <= error_d;
      fault_q <= fault_d;
      mc_q <= mc_d;
      mcr_q <= mcr_d;
      env_q <= env_d;
      idx_q <= idx_d;
      bytes_q <= bytes_d;
      left_q <= left_d;
      cur_q <= cur_d;
    end
  end

  // sector buffer, no reset needed on the storage itself
  always_ff @(posedge CLK)
  begin
    if (mem_we)
      buf_mem[idx_q] <= WB_DAT_I[7:0];
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign DMA_REQ = dmarq_q;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_buf_enters_pio: assert property (
    cmd_wr && WB_DAT_I[7:0] == OP_BUF_WRITE && env_q[EC_BUF_SUP]
    && !env_q[EC_PACKET] |=> st_q == ST_PIO && status[ST_DRQ])
    else $error("buffer write did not enter pio phase");

  a_pio_sector_end: assert property (
    st_q == ST_PIO && hit(wr, WB_ADR_I, IX_PIO_DATA) && idx_q == SECT_LAST
    && !ev[EV_FAULT] |=> st_q == ST_IDLE && error_q == 8'h00)
    else $error("pio phase did not end after 512 bytes");

  a_buf_unsup_abort: assert property (
    cmd_wr && WB_DAT_I[7:0] == OP_BUF_WRITE && !env_q[EC_BUF_SUP]
    |=> error_q[ER_ABORTED_FLAG] && status[ST_ERR] && st_q == ST_IDLE)
    else $error("unsupported buffer write not aborted");

  a_ok_status: assert property (
    st_q != ST_IDLE ##1 st_q == ST_IDLE && error_q == 8'h00
    |-> status == 8'h40)
    else $error("good completion status wrong");

  a_err_mirror: assert property (
    fin_err |=> status[ST_ERR] && !status[ST_BUSY] && !status[ST_DRQ])
    else $error("error completion shows no failure flag");

  a_count_zero: assert property (
    cmd_wr && WB_DAT_I[7:0] == OP_DMA_WRITE && cnt_q == CNT_ZERO
    && !env_q[EC_PACKET] |=> left_q == SECT_FULL)
    else $error("zero count not taken as 256 sectors");

  a_crc_ultra: assert property (
    st_q == ST_DMA && ev[EV_CRC] && env_q[EC_ULTRA] && !ev[EV_FAULT]
    && !ev[EV_UNRECOV] |=> error_q[ER_INTERFACE_CRC_FLAG] && error_q[ER_ABORTED_FLAG] && !DMA_REQ)
    else $error("ultra crc error not reported");

  a_packet_refuse: assert property (
    cmd_wr && env_q[EC_PACKET] |=> st_q == ST_IDLE ##0 error_q[ER_ABORTED_FLAG])
    else $error("packet device accepted a write command");

  a_fail_address: assert property (
    st_q == ST_DMA && ev[EV_UNRECOV] && !ev[EV_FAULT]
    |=> start_addr == $past(cur_q))
    else $error("failing sector address not loaded");

  c_pio_done: cover property (st_q == ST_PIO ##1 st_q == ST_IDLE
    && error_q == 8'h00);
  c_dma_done: cover property (st_q == ST_DMA ##1 st_q == ST_IDLE
    && error_q == 8'h00);
  c_dma_crc: cover property (st_q == ST_DMA ##1 error_q[ER_INTERFACE_CRC_FLAG]);
endmodule

// File: shared/wrcmd_pkg.sv
// shared constants for the buffer-write and dma-write command block
package wrcmd_pkg;
  // register word indices, byte address is index times four
  localparam logic [3:0] IX_FEATURE = 4'h0;
  localparam logic [3:0] IX_COUNT = 4'h1;
  localparam logic [3:0] IX_ADDR_LOW = 4'h2;
  localparam logic [3:0] IX_ADDR_MID = 4'h3;
  localparam logic [3:0] IX_ADDR_HIGH = 4'h4;
  localparam logic [3:0] IX_DSH = 4'h5;
  localparam logic [3:0] IX_CMD_STAT = 4'h6;
  localparam logic [3:0] IX_ERROR = 4'h7;
  localparam logic [3:0] IX_PIO_DATA = 4'h8;
  localparam logic [3:0] IX_DMA_DATA = 4'h9;
  localparam logic [3:0] IX_ENV_CTRL = 4'ha;
  localparam logic [3:0] IX_ENV_EVT = 4'hb;
  // opcodes
  localparam logic [7:0] OP_BUF_WRITE = 8'he8;
  localparam logic [7:0] OP_DMA_WRITE = 8'hca;
  // error cause bit positions
  localparam int ER_INTERFACE_CRC_FLAG = 7;
  localparam int ER_WP = 6;
  localparam int ER_MC = 5;
  localparam int ER_ADDR_NOT_FOUND_FLAG = 4;
  localparam int ER_MCR = 3;
  localparam int ER_ABORTED_FLAG = 2;
  localparam int ER_NM = 1;
  // status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_DEVICE_READY_FLAG = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  // drive select/head fields
  localparam int DSH_LBA = 6;
  localparam int DSH_DEV = 4;
  // environment control bits
  localparam int EC_BUF_SUP = 0;
  localparam int EC_PACKET = 1;
  localparam int EC_NO_MEDIA = 2;
  localparam int EC_WPROT = 3;
  localparam int EC_ULTRA = 4;
  localparam int EC_GEOM_BAD = 5;
  localparam logic [5:0] ENV_RESET = 6'h01;
  // environment event bits, write one to fire
  localparam int EV_MEDIA_CHG = 0;
  localparam int EV_CHG_REQ = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_CRC = 3;
  localparam int EV_UNRECOV = 4;
  // sector geometry
  localparam logic [8:0] SECT_LAST = 9'h1ff;
  localparam logic [8:0] SECT_FULL = 9'h100;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PIO = 3'b010,
    ST_DMA = 3'b100
  } state_t;
endpackage
